// File: shared/vfia_pkg.sv
// Shared constants and types of the vertex fetch and input assembly stage.
package vfia_pkg;

    // ------------------------------------------------------------------
    // Command opcodes
    // ------------------------------------------------------------------
    // Codes that are not listed here, and OP_OTHER, are forwarded downstream untouched.
    typedef enum logic [2:0] {
        OP_DRAW    = 3'h0,
        OP_IDXST   = 3'h1,
        OP_VBST    = 3'h2,
        OP_ELST    = 3'h3,
        OP_STATS   = 3'h4,
        OP_OTHER   = 3'h5
    } vfia_op_t;

    // ------------------------------------------------------------------
    // Per-component source control
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        COMP_MEM     = 3'h0,
        COMP_ZERO    = 3'h1,
        COMP_ONE_INT = 3'h2,
        COMP_ONE_FLT = 3'h3,
        COMP_VTXNUM  = 3'h4,
        COMP_INSTNUM = 3'h5,
        COMP_PRIMNUM = 3'h6,
        COMP_NONE    = 3'h7
    } vfia_comp_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_IDX  = 3'h1,
        S_IDXW = 3'h2,
        S_LOOK = 3'h3,
        S_COMP = 3'h4,
        S_MEMR = 3'h5,
        S_MEMW = 3'h6,
        S_EMIT = 3'h7
    } vfia_state_t;

    localparam logic [31:0] CONST_ZERO    = 32'h00000000;
    localparam logic [31:0] CONST_ONE_INT = 32'h00000001;
    localparam logic [31:0] CONST_ONE_FLT = 32'h3f800000;

    localparam logic [1:0]  IDX_FMT_BYTE  = 2'h0;
    localparam logic [1:0]  IDX_FMT_WORD  = 2'h1;
    localparam logic [1:0]  IDX_FMT_DWORD = 2'h2;
    localparam int          COMPS_PER_ELEM = 4;

    // Field layout of the three argument words of a command.
    localparam int DRAW_VCNT_LSB = 0;
    localparam int DRAW_ICNT_LSB = 16;
    localparam int DRAW_IDXD_BIT = 0;
    localparam int DRAW_VPP_LSB  = 1;
    localparam int IDXST_CUT_BIT = 2;
    localparam int VBST_INST_BIT = 4;
    localparam int ELST_VAL_BIT  = 4;
    localparam int ELST_SRC_LSB  = 4;
    localparam int ELST_DST_LSB  = 16;
    localparam int ELST_F16_BIT  = 24;
    localparam int COMP_CTRL_W   = 3;

endpackage

// File: rtl/vfia_stage.sv
// Vertex fetch and input assembly stage with vertex cache and command forwarding.
`timescale 1ns/100ps
module vfia_stage #(
    parameter int NUM_ELEM = 8,
    parameter int NUM_BUF  = 8,
    parameter int NUM_RB   = 16
) (
    input  wire logic                ref_clk,
    input  wire logic                reset_n,
    input  wire logic                cmdValid,
    output logic                     cmdReady,
    input  wire vfia_pkg::vfia_op_t  cmdOp,
    input  wire logic [31:0]         cmdArg0,
    input  wire logic [31:0]         cmdArg1,
    input  wire logic [31:0]         cmdArg2,
    input  wire logic                cacheEnable,
    output logic                     fwdValid,
    input  wire logic                fwdReady,
    output vfia_pkg::vfia_op_t       fwdOp,
    output logic [31:0]              fwdArg0,
    output logic [31:0]              fwdArg1,
    output logic [31:0]              fwdArg2,
    output logic                     memReqValid,
    input  wire logic                memReqReady,
    output logic [31:0]              memReqAddr,
    input  wire logic                memRspValid,
    input  wire logic [31:0]         memRspData,
    output logic                     rbWrValid,
    output logic [$clog2(NUM_RB)-1:0] rbWrEntry,
    output logic [7:0]               rbWrDword,
    output logic [31:0]              rbWrData,
    output logic                     outValid,
    input  wire logic                outReady,
    output logic [$clog2(NUM_RB)-1:0] outHandle,
    output logic                     outCut,
    output logic [31:0]              outPrimNumber,
    output logic [31:0]              statVertexCount
);
    import vfia_pkg::*;

    localparam int HW = $clog2(NUM_RB);
    localparam int EW = $clog2(NUM_ELEM) + 1;
    localparam int BW = $clog2(NUM_BUF);

    if (NUM_ELEM < 2 || NUM_ELEM > 16 || NUM_BUF < 2 || NUM_BUF > 16 ||
        NUM_RB < 2 || (NUM_RB & (NUM_RB - 1)) != 0) begin : g_check
        $error("vfia_stage: unsupported parameter values");
    end

    // ------------------------------------------------------------------
    // State held from state commands
    // ------------------------------------------------------------------
    vfia_state_t      stateQ;
    logic [31:0]      ibStartQ, ibEndQ;
    logic [1:0]       ibFmtQ;
    logic             ibCutQ, statsEnQ, fwdValidQ;
    vfia_op_t         fwdOpQ;
    logic [31:0]      fwdArg0Q, fwdArg1Q, fwdArg2Q;
    logic [31:0]      vbBaseQ  [NUM_BUF];
    logic [15:0]      vbPitchQ [NUM_BUF];
    logic             vbInstQ  [NUM_BUF];
    logic             elValidQ [NUM_ELEM];
    logic [BW-1:0]    elBufQ   [NUM_ELEM];
    logic [11:0]      elSrcQ   [NUM_ELEM];
    logic [7:0]       elDstQ   [NUM_ELEM];
    logic             elF16Q   [NUM_ELEM];
    logic [11:0]      elCtrlQ  [NUM_ELEM];

    wire logic accept = cmdValid && cmdReady;
    assign cmdReady = (stateQ == S_IDLE) && !fwdValidQ;

    // Only listed state commands land here; nothing is fetched through pointers.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ibStartQ <= '0;
            ibEndQ   <= '0;
            ibFmtQ   <= IDX_FMT_BYTE;
            ibCutQ   <= 1'b0;
            statsEnQ <= 1'b0;
            for (int i = 0; i < NUM_BUF; i++) begin
                vbBaseQ[i]  <= '0;
                vbPitchQ[i] <= '0;
                vbInstQ[i]  <= 1'b0;
            end
            for (int i = 0; i < NUM_ELEM; i++) begin
                elValidQ[i] <= 1'b0;
                elBufQ[i]   <= '0;
                elSrcQ[i]   <= '0;
                elDstQ[i]   <= '0;
                elF16Q[i]   <= 1'b0;
                elCtrlQ[i]  <= '0;
            end
        end else if (accept) begin
            unique case (cmdOp)
                OP_IDXST: begin
                    ibStartQ <= cmdArg0;
                    ibEndQ   <= cmdArg1;
                    ibFmtQ   <= cmdArg2[1:0];
                    ibCutQ   <= cmdArg2[IDXST_CUT_BIT];
                end
                OP_VBST: begin
                    vbBaseQ[cmdArg2[BW-1:0]]  <= cmdArg0;
                    vbPitchQ[cmdArg2[BW-1:0]] <= cmdArg1[15:0];
                    vbInstQ[cmdArg2[BW-1:0]]  <= cmdArg2[VBST_INST_BIT];
                end
                OP_ELST: begin
                    elValidQ[cmdArg2[EW-2:0]] <= cmdArg2[ELST_VAL_BIT];
                    elBufQ[cmdArg2[EW-2:0]]   <= cmdArg0[BW-1:0];
                    elSrcQ[cmdArg2[EW-2:0]]   <= cmdArg0[ELST_SRC_LSB +: 12];
                    elDstQ[cmdArg2[EW-2:0]]   <= cmdArg0[ELST_DST_LSB +: 8];
                    elF16Q[cmdArg2[EW-2:0]]   <= cmdArg0[ELST_F16_BIT];
                    elCtrlQ[cmdArg2[EW-2:0]]  <= cmdArg1[11:0];
                end
                OP_STATS: statsEnQ <= cmdArg0[0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Forwarding of commands this stage does not own
    // ------------------------------------------------------------------
    wire logic isOwn = (cmdOp == OP_DRAW) || (cmdOp == OP_IDXST) || (cmdOp == OP_VBST) ||
                       (cmdOp == OP_ELST) || (cmdOp == OP_STATS);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fwdValidQ <= 1'b0;
            fwdOpQ    <= OP_OTHER;
            fwdArg0Q  <= '0;
            fwdArg1Q  <= '0;
            fwdArg2Q  <= '0;
        end else if (accept && !isOwn) begin
            fwdValidQ <= 1'b1;
            fwdOpQ    <= cmdOp;
            fwdArg0Q  <= cmdArg0;
            fwdArg1Q  <= cmdArg1;
            fwdArg2Q  <= cmdArg2;
        end else if (fwdReady) begin
            fwdValidQ <= 1'b0;
        end
    end
    assign fwdValid = fwdValidQ;
    assign fwdOp    = fwdOpQ;
    assign fwdArg0  = fwdArg0Q;
    assign fwdArg1  = fwdArg1Q;
    assign fwdArg2  = fwdArg2Q;

    // ------------------------------------------------------------------
    // Derived element usage
    // ------------------------------------------------------------------
    logic anyMem, instUsed, primUsed;
    always_comb begin
        anyMem   = 1'b0;
        instUsed = 1'b0;
        primUsed = 1'b0;
        for (int e = 0; e < NUM_ELEM; e++) begin
            for (int c = 0; c < COMPS_PER_ELEM; c++) begin
                if (elValidQ[e] && elCtrlQ[e][c*COMP_CTRL_W +: COMP_CTRL_W] == COMP_MEM) begin
                    anyMem   = 1'b1;
                    instUsed = instUsed | vbInstQ[elBufQ[e]];
                end
                if (elValidQ[e] && elCtrlQ[e][c*COMP_CTRL_W +: COMP_CTRL_W] == COMP_INSTNUM)
                    instUsed = 1'b1;
                if (elValidQ[e] && elCtrlQ[e][c*COMP_CTRL_W +: COMP_CTRL_W] == COMP_PRIMNUM)
                    primUsed = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Draw sequencing
    // ------------------------------------------------------------------
    logic [31:0]   startQ, lookupQ, vertQ, instQ, primQ, idxAddrQ;
    logic [15:0]   vcntQ, icntQ;
    logic [1:0]    vppQ, inPrimQ;
    logic          indexedQ, cutQ;
    logic [EW-1:0] elemQ;
    logic [1:0]    compQ;
    logic [HW-1:0] handleQ;
    logic          cacheValidQ [NUM_RB];
    logic [31:0]   cacheTagQ   [NUM_RB];

    wire logic [HW-1:0] slot   = lookupQ[HW-1:0];
    wire logic          hit    = cacheEnable && !primUsed && cacheValidQ[slot] &&
                                 cacheTagQ[slot] == lookupQ;
    wire logic [31:0]   idxPos = startQ + vertQ;
    wire logic [31:0]   idxAdr = ibStartQ + (idxPos << ibFmtQ);
    wire logic [31:0]   lane   = memRspData >> {idxAddrQ[1:0], 3'b000};
    wire logic          lastV  = (vertQ + 32'h1) == {16'h0, vcntQ};
    wire logic          lastI  = (instQ + 32'h1) == {16'h0, icntQ};
    wire logic          needIx = indexedQ && anyMem;
    wire logic [EW-2:0] eSel   = elemQ[EW-2:0];
    // Inactive element records are walked as no-store so that they never fetch or write.
    wire vfia_comp_t    ctrl   = !elValidQ[eSel] ? COMP_NONE :
                                 vfia_comp_t'(elCtrlQ[eSel][compQ*COMP_CTRL_W +: COMP_CTRL_W]);
    wire logic          elemDone = (elemQ == EW'(NUM_ELEM));
    wire logic [31:0]   bufIdx = vbInstQ[elBufQ[eSel]] ? instQ : lookupQ;
    wire logic [31:0]   memAdr = vbBaseQ[elBufQ[eSel]] + 32'(bufIdx * vbPitchQ[elBufQ[eSel]]) +
                                 {20'h0, elSrcQ[eSel]} + {28'h0, compQ, 2'b00};

    logic [31:0] idxVal, cutVal, constVal;
    always_comb begin
        unique case (ibFmtQ)
            IDX_FMT_BYTE: begin
                idxVal = {24'h0, lane[7:0]};
                cutVal = 32'h000000ff;
            end
            IDX_FMT_WORD: begin
                idxVal = {16'h0, lane[15:0]};
                cutVal = 32'h0000ffff;
            end
            default: begin
                idxVal = memRspData;
                cutVal = 32'hffffffff;
            end
        endcase
        if (idxAddrQ > ibEndQ)
            idxVal = CONST_ZERO;
        unique case (ctrl)
            COMP_ONE_INT: constVal = CONST_ONE_INT;
            COMP_ONE_FLT: constVal = CONST_ONE_FLT;
            COMP_VTXNUM:  constVal = lookupQ;
            COMP_INSTNUM: constVal = instQ;
            COMP_PRIMNUM: constVal = primQ;
            default:      constVal = CONST_ZERO;
        endcase
    end

    wire logic advVert = (stateQ == S_EMIT) && outReady;
    wire logic drawGo  = accept && cmdOp == OP_DRAW &&
                         cmdArg1[DRAW_VCNT_LSB +: 16] != 16'h0 &&
                         cmdArg1[DRAW_ICNT_LSB +: 16] != 16'h0;
    wire logic compAdv = (stateQ == S_COMP && !elemDone && ctrl != COMP_MEM) ||
                         (stateQ == S_MEMW && memRspValid);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stateQ   <= S_IDLE;
            startQ   <= '0;
            vcntQ    <= '0;
            icntQ    <= '0;
            vppQ     <= 2'h1;
            indexedQ <= 1'b0;
            vertQ    <= '0;
            instQ    <= '0;
            lookupQ  <= '0;
            idxAddrQ <= '0;
            cutQ     <= 1'b0;
            elemQ    <= '0;
            compQ    <= '0;
            handleQ  <= '0;
        end else begin
            unique case (stateQ)
                S_IDLE: if (drawGo) begin
                    startQ   <= cmdArg0;
                    vcntQ    <= cmdArg1[DRAW_VCNT_LSB +: 16];
                    icntQ    <= cmdArg1[DRAW_ICNT_LSB +: 16];
                    vppQ     <= cmdArg2[DRAW_VPP_LSB +: 2];
                    indexedQ <= cmdArg2[DRAW_IDXD_BIT];
                    vertQ    <= '0;
                    instQ    <= '0;
                    lookupQ  <= cmdArg0;
                    stateQ   <= (cmdArg2[DRAW_IDXD_BIT] && anyMem) ? S_IDX : S_LOOK;
                end
                S_IDX: begin
                    idxAddrQ <= idxAdr;
                    if (memReqReady)
                        stateQ <= S_IDXW;
                end
                S_IDXW: if (memRspValid) begin
                    lookupQ <= idxVal;
                    cutQ    <= ibCutQ && idxAddrQ <= ibEndQ && idxVal == cutVal;
                    stateQ  <= (ibCutQ && idxAddrQ <= ibEndQ && idxVal == cutVal) ? S_EMIT : S_LOOK;
                end
                S_LOOK: begin
                    elemQ   <= '0;
                    compQ   <= '0;
                    handleQ <= slot;
                    stateQ  <= hit ? S_EMIT : S_COMP;
                end
                S_COMP: begin
                    if (elemDone)
                        stateQ <= S_EMIT;
                    else if (ctrl == COMP_MEM)
                        stateQ <= S_MEMR;
                end
                S_MEMR: if (memReqReady)
                    stateQ <= S_MEMW;
                S_MEMW: if (memRspValid)
                    stateQ <= S_COMP;
                S_EMIT: if (outReady) begin
                    cutQ    <= 1'b0;
                    vertQ   <= lastV ? 32'h0 : vertQ + 32'h1;
                    instQ   <= lastV ? instQ + 32'h1 : instQ;
                    lookupQ <= startQ + (lastV ? 32'h0 : vertQ + 32'h1);
                    if (lastV && lastI)
                        stateQ <= S_IDLE;
                    else
                        stateQ <= needIx ? S_IDX : S_LOOK;
                end
            endcase
            if (compAdv) begin
                compQ <= compQ + 2'h1;
                if (compQ == 2'h3)
                    elemQ <= elemQ + EW'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // Vertex cache, primitive numbering and statistics
    // ------------------------------------------------------------------
    // The cache is cleared at every draw with nonzero counts, since state may have changed in between.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_RB; i++) begin
                cacheValidQ[i] <= 1'b0;
                cacheTagQ[i]   <= '0;
            end
        end else if (drawGo || (advVert && lastV && instUsed)) begin
            for (int i = 0; i < NUM_RB; i++)
                cacheValidQ[i] <= 1'b0;
        end else if (stateQ == S_COMP && elemDone) begin
            cacheValidQ[handleQ] <= 1'b1;
            cacheTagQ[handleQ]   <= lookupQ;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            primQ           <= '0;
            inPrimQ         <= '0;
            statVertexCount <= '0;
        end else if (drawGo) begin
            primQ   <= '0;
            inPrimQ <= '0;
        end else if (advVert) begin
            if (statsEnQ && !cutQ)
                statVertexCount <= statVertexCount + 32'h1;
            if (cutQ || lastV) begin
                inPrimQ <= '0;
                primQ   <= (inPrimQ != 2'h0 || !cutQ) ? primQ + 32'h1 : primQ;
            end else if (inPrimQ + 2'h1 >= vppQ) begin
                inPrimQ <= '0;
                primQ   <= primQ + 32'h1;
            end else begin
                inPrimQ <= inPrimQ + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Return buffer writes
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rbWrValid <= 1'b0;
            rbWrEntry <= '0;
            rbWrDword <= '0;
            rbWrData  <= '0;
        end else begin
            rbWrValid <= compAdv && !(stateQ == S_COMP && ctrl == COMP_NONE);
            rbWrEntry <= handleQ;
            rbWrDword <= elDstQ[eSel] + {6'h0, compQ};
            rbWrData  <= (stateQ == S_MEMW) ?
                         (elF16Q[eSel] ? {16'h0, memRspData[15:0]} : memRspData) :
                         constVal;
        end
    end

    assign memReqValid   = (stateQ == S_IDX) || (stateQ == S_MEMR);
    assign memReqAddr    = (stateQ == S_IDX) ? {idxAdr[31:2], 2'b00} : memAdr;
    assign outValid      = (stateQ == S_EMIT);
    assign outHandle     = handleQ;
    assign outCut        = cutQ;
    assign outPrimNumber = primQ;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence idxRspCut;
        stateQ == S_IDXW && memRspValid && ibCutQ && idxAddrQ <= ibEndQ && idxVal == cutVal;
    endsequence
    sequence missWalk;
        stateQ == S_LOOK && !hit ##1 stateQ == S_COMP;
    endsequence

    own_consumed_a: assert property (accept && isOwn |=> !$rose(fwdValidQ))
        else $error("owned command was forwarded");
    fwd_copy_a: assert property (accept && !isOwn |=> fwdValid && fwdArg0 == $past(cmdArg0)
        && fwdOp == $past(cmdOp))
        else $error("foreign command not forwarded unchanged");
    hit_no_fetch_a: assert property (stateQ == S_LOOK && hit |=> stateQ == S_EMIT)
        else $error("cache hit did not emit directly");
    miss_fill_a: assert property (missWalk |-> !outValid)
        else $error("cache miss emitted before assembly");
    idx_zero_a: assert property (stateQ == S_IDXW && memRspValid && idxAddrQ > ibEndQ
        && !ibCutQ |=> lookupQ == 32'h0)
        else $error("out of range index not zero");
    no_idx_read_a: assert property (stateQ == S_IDX |-> indexedQ && anyMem)
        else $error("index read without need");
    stats_set_a: assert property (accept && cmdOp == OP_STATS
        |=> statsEnQ == $past(cmdArg0[0]))
        else $error("statistics enable not taken");
    cut_mark_a: assert property (idxRspCut |=> outValid && outCut)
        else $error("cut index not marked");
    inst_clear_a: assert property (advVert && lastV && instUsed && !lastI
        |=> !cacheValidQ[slot])
        else $error("cache survived instance change");
    ib_replace_a: assert property (accept && cmdOp == OP_IDXST
        |=> ibStartQ == $past(cmdArg0))
        else $error("index state not replaced");

endmodule

// File: tb/vfia_mem_model.sv
// Graphics memory model that serves one read at a time with a varying delay.
`timescale 1ns/100ps
module vfia_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        memReqValid,
    output logic             memReqReady,
    input  wire logic [31:0] memReqAddr,
    output logic             memRspValid,
    output logic [31:0]      memRspData
);
    logic [31:0] addr_q;
    logic [3:0]  pace_q;
    logic [2:0]  wait_q;
    logic        busy_q;
    // ------------------------------------------------------------------
    // Read service
    // ------------------------------------------------------------------
    // Idle data flips every cycle so that a stale word never looks valid.
    assign memReqReady = !busy_q && pace_q[0];
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            {addr_q, pace_q, wait_q, busy_q, memRspValid, memRspData} <= '0;
        end else begin
            pace_q <= pace_q + 4'h1;
            memRspValid <= 1'b0;
            memRspData <= ~memRspData;
            if (memReqValid && memReqReady) begin
                busy_q <= 1'b1;
                addr_q <= memReqAddr;
                wait_q <= pace_q[3:1];
            end else if (busy_q && wait_q == 3'h0) begin
                busy_q <= 1'b0;
                memRspValid <= 1'b1;
                memRspData <= ~addr_q;
            end else if (busy_q) begin
                wait_q <= wait_q - 3'h1;
            end
        end
    end
endmodule

// File: tb/tb.sv
// Self-checking bench for the vertex fetch and input assembly stage.
`timescale 1ns/100ps
module tb;
    import vfia_pkg::*;
    logic        ref_clk = 1'b0, reset_n = 1'b0, cmdValid = 1'b0, cacheEnable = 1'b0;
    logic        fwdReady = 1'b0, outReady = 1'b0;
    logic        cmdReady, fwdValid, memReqValid, memReqReady, memRspValid, rbWrValid;
    logic        outValid, outCut;
    vfia_op_t    cmdOp = OP_DRAW, fwdOp;
    logic [31:0] cmdArg0 = 32'h0, cmdArg1 = 32'h0, cmdArg2 = 32'h0;
    logic [31:0] fwdArg0, fwdArg1, fwdArg2, memReqAddr, memRspData, statVertexCount, rbWrData;
    logic [7:0]  rbWrDword;
    logic [31:0] rnd = 32'ha0a9efd9, vb, a, n, e, nStat = 32'h0;
    logic [3:0]  rbWrEntry, outHandle;
    logic [31:0] outPrimNumber;
    logic [98:0] fq[$];
    logic [32:0] vq[$];
    int          n_errors = 0, checks = 0, pn = 0;
    bit          bt;
    // ------------------------------------------------------------------
    // Design, memory and helpers
    // ------------------------------------------------------------------
    vfia_stage uut (.ref_clk, .reset_n, .cmdValid, .cmdReady, .cmdOp, .cmdArg0, .cmdArg1,
        .cmdArg2, .cacheEnable, .fwdValid, .fwdReady, .fwdOp, .fwdArg0, .fwdArg1, .fwdArg2,
        .memReqValid, .memReqReady, .memReqAddr, .memRspValid, .memRspData, .rbWrValid,
        .rbWrEntry, .rbWrDword, .rbWrData, .outValid, .outReady, .outHandle, .outCut,
        .outPrimNumber, .statVertexCount);
    vfia_mem_model mem (.ref_clk, .reset_n, .memReqValid, .memReqReady, .memReqAddr,
        .memRspValid, .memRspData);
    always #10 ref_clk = ~ref_clk;
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Dword 0 comes from the vertex array with pitch 4, dwords 1 and 2 are constants and the rest give the vertex number.
    function automatic logic [31:0] word(input logic [7:0] d, input logic [31:0] v);
        case (d)
            8'h00: return ~(vb + {v[29:0], 2'b00});
            8'h01: return 32'h00000001;
            8'h02: return 32'h3f800000;
            default: return v;
        endcase
    endfunction
    // Expected index entry; bit 32 marks a cut, and reads past the end give zero.
    function automatic logic [32:0] ixv(input logic [31:0] p, input logic [31:0] l, input bit b);
        logic [31:0] w;
        w = b ? ((~{p[31:2], 2'b00}) >> {p[1:0], 3'b000}) & 32'hff : ~p;
        if (p > l) return 33'h0;
        return {b && w == 32'hff, w};
    endfunction
    task automatic chk(input string nm, input logic [98:0] e, input logic [98:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop;
        if (n_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic send(input vfia_op_t op, input logic [31:0] a0, a1, a2);
        @(posedge ref_clk);
        cmdOp <= op;
        cmdArg0 <= a0;
        cmdArg1 <= a1;
        cmdArg2 <= a2;
        cmdValid <= 1'b1;
        do @(posedge ref_clk); while (cmdReady !== 1'b1);
        cmdValid <= 1'b0;
        if (op > OP_STATS) fq.push_back({op, a0, a1, a2});
    endtask
    // ------------------------------------------------------------------
    // Monitors and stimulus
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        rnd <= nx(rnd);
        outReady <= rnd[3];
        fwdReady <= rnd[9];
        if (reset_n && rbWrValid) begin
            chk("record dword", word(rbWrDword, vq[0][31:0]), rbWrData);
            chk("record entry", vq[0][3:0], rbWrEntry);
        end
        if (reset_n && outValid && outReady) begin
            chk("cut flag", vq[0][32], outCut);
            if (!vq[0][32]) chk("handle", vq[0][3:0], outHandle);
            chk("prim number", pn, outPrimNumber);
            pn = (vq.size() == 1) ? 0 : pn + (vq[0][32] ? 0 : 1);
            void'(vq.pop_front());
        end
        if (reset_n && fwdValid && fwdReady)
            chk("forwarded", fq.pop_front(), {fwdOp, fwdArg0, fwdArg1, fwdArg2});
    end
    initial begin
        #400000;
        chk("timeout", 0, 1);
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        send(OP_ELST, 32'h0, 32'h8d0, 32'h10);
        for (int k = 0; k < 6; k++) begin
            send(OP_STATS, {31'h0, k < 5}, rnd, rnd);
            send(vfia_op_t'(3'(5 + k % 3)), rnd, ~rnd, nx(rnd));
            vb = {16'h0, rnd[23:16], 8'h0};
            send(OP_VBST, vb, 32'h4, 32'h0);
            a = {20'h1, rnd[7:0], 4'h0};
            bt = (k == 5);
            n = bt ? 6 : 3 + rnd[1:0];
            e = a + (bt ? 8 * k + n - 3 : 32 * k + 4 * n - 9);
            send(OP_IDXST, a, e, bt ? 32'h4 : 32'h2);
            for (int i = 0; i < n; i++)
                vq.push_back(k[0] ? ixv(a + (bt ? 8 * k + i : 32 * k + 4 * i), e, bt)
                                  : 8 * k + i);
            if (k < 5) nStat += n;
            cacheEnable <= rnd[5];
            send(OP_DRAW, 8 * k, {16'h1, n[15:0]}, {29'h0, 2'h1, k[0]});
            do @(posedge ref_clk); while (cmdReady !== 1'b1);
        end
        repeat (20) @(posedge ref_clk);
        chk("stat count", nStat, statVertexCount);
        chk("left over", {fq.size(), vq.size()}, 0);
        report_and_stop();
    end
endmodule
